// File: rtl/timer_cap_pkg.sv
// constants for the four-channel capture timer
package timer_cap_pkg;
  localparam int count_width = 16;
  localparam int channels = 4;
  localparam int prescale_div = 4; // oscillator periods per instruction cycle
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] period_reset = 16'hffff;
  // edge mode codes
  localparam logic [1:0] edge_rise = 2'h0;
  localparam logic [1:0] edge_fall = 2'h1;
  localparam logic [1:0] edge_rise4 = 2'h2;
  localparam logic [1:0] edge_rise16 = 2'h3;
  localparam logic [3:0] rise4_last = 4'h3;
  localparam logic [3:0] rise16_last = 4'hf;
endpackage

// File: rtl/timer_with_four_capture.sv
// 16-bit timer with four capture channels and period mode
// Operation
// [R1] 16-bit count readable as high and low bytes
// [R2] source clear: count every instruction cycle
// [R3] source set: count external pin falling edges
// [R4] run bit clear stops count and flag
// [R5] mode bit selects period or four captures
// [R6] first pair is period or capture one
// [R7] qualified event copies count into channel pair
// [R8] four capture pins, one per pair
// [R9] edge: rise, fall, 4th rise, 16th rise
// [R10] channel flag set on each capture
// [R11] period match returns count to zero next tick
// [R12] timer flag set on return to zero
// [R13] interrupt request only when enable set
// [R14] software clears the timer flag
// [R15] two-bit edge mode code per channel
// [R16] external inputs synchronized before edge detection
`timescale 1ns/100ps
module timer_with_four_capture
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic clock_source_select_in,
  input wire logic timer_run_in,
  input wire logic period_capture_mode_select_in,
  input wire logic timer_irq_enable_in,
  input wire logic timer_irq_flag_clear_in,
  input wire logic period_write_in,
  input wire logic [15:0] period_data_in,
  input wire logic [7:0] edge_mode_in,
  input wire logic [3:0] capture_flag_clear_in,
  input wire logic external_count_pin_in,
  input wire logic capture_pin_one_in,
  input wire logic capture_pin_two_in,
  input wire logic capture_pin_three_in,
  input wire logic capture_pin_four_in,
  output logic [7:0] timer_count_high_out,
  output logic [7:0] timer_count_low_out,
  output logic [7:0] period_or_capture1_high_out,
  output logic [7:0] period_or_capture1_low_out,
  output logic [47:0] capture_234_out,
  output logic timer_irq_flag_out,
  output logic [3:0] capture_flag_out,
  output logic timer_irq_out
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [1:0] presc;
    logic [15:0] count;
    logic [3:0][15:0] cap;
    logic [3:0][3:0] evcnt;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] prev;
    logic tflag;
    logic [3:0] cflag;
  } state_type;

  state_type st;
  state_type next_st;
  logic [3:0] pins;
  logic tick;
  wire [3:0] fire;
  logic [4:0] rise;
  logic [4:0] fall;

  // ****************************************
  // elaboration checks
  // ****************************************
  // the prescaler is two bits and the channel fabric is fixed at four
  if (timer_cap_pkg::channels != 4)
  begin : g_bad_channels
    $error("only four channels supported");
  end
  if (timer_cap_pkg::prescale_div != 4)
  begin : g_bad_prescale
    $error("prescaler divides by four only");
  end
  if (timer_cap_pkg::count_width != 16)
  begin : g_bad_width
    $error("count must be sixteen bits");
  end

  // ****************************************
  // pin edges and timer clock
  // ****************************************
  assign pins = {capture_pin_four_in, capture_pin_three_in,
                 capture_pin_two_in, capture_pin_one_in}; // [R8]
  // edges judged only after the second stage
  assign rise = st.sync2 & ~st.prev; // [R16]
  assign fall = ~st.sync2 & st.prev;
  // internal tick every fourth mclk, or external falling edge
  assign tick = timer_run_in & (clock_source_select_in ? fall[4]
    : (st.presc == 2'(timer_cap_pkg::prescale_div - 1))); // [R2] [R3] [R4]

  // ****************************************
  // channel events
  // ****************************************
  // per-channel event qualification; one driver per bit of fire
  for (genvar i = 0; i < 4; i++)
  begin : g_ch
    logic [1:0] code;
    assign code = edge_mode_in[2*i +: 2]; // [R15]
    // divided modes fire when the rise counter ends its run
    assign fire[i] = (code == timer_cap_pkg::edge_rise) ? rise[i]
      : (code == timer_cap_pkg::edge_fall) ? fall[i]
      : (code == timer_cap_pkg::edge_rise4) ? (rise[i] &
        (st.evcnt[i][1:0] == timer_cap_pkg::rise4_last[1:0]))
      : (rise[i] & (st.evcnt[i] == timer_cap_pkg::rise16_last)); // [R9]
  end

  // ****************************************
  // next state
  // ****************************************
  // next-state logic
  always_comb
  begin
    next_st = st;
    next_st.sync1 = {external_count_pin_in, pins};
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    next_st.presc = 2'(st.presc + 2'h1);
    // clear first, so that a set in the same cycle wins
    if (timer_irq_flag_clear_in)
      next_st.tflag = 1'b0; // [R14]
    if (tick)
    begin
      // period match wraps on the following tick
      if (!period_capture_mode_select_in && st.count == st.cap[0])
      begin
        next_st.count = timer_cap_pkg::count_reset; // [R11]
        next_st.tflag = 1'b1; // [R12]
      end
      else
      begin
        next_st.count = 16'(st.count + 16'h0001); // [R1]
        // free-running wrap in four-capture mode also flags
        if (st.count == 16'hffff)
          next_st.tflag = 1'b1;
      end
    end
    if (!period_capture_mode_select_in && period_write_in)
      next_st.cap[0] = period_data_in; // [R6]
    for (int i = 0; i < 4; i++)
    begin
      if (rise[i])
        next_st.evcnt[i] = 4'(st.evcnt[i] + 4'h1);
      if (capture_flag_clear_in[i])
        next_st.cflag[i] = 1'b0;
      // channel one captures only in four-capture mode
      if (fire[i] && (i != 0 || period_capture_mode_select_in))
      begin
        next_st.cap[i] = st.count; // [R7] [R5]
        next_st.cflag[i] = 1'b1; // [R10]
      end
    end
  end

  // state register
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st <= '0;
      st.cap[0] <= timer_cap_pkg::period_reset;
    end
    else
      st <= next_st;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign timer_count_high_out = st.count[15:8];
  assign timer_count_low_out = st.count[7:0];
  assign period_or_capture1_high_out = st.cap[0][15:8];
  assign period_or_capture1_low_out = st.cap[0][7:0];
  assign capture_234_out = {st.cap[3], st.cap[2], st.cap[1]};
  assign timer_irq_flag_out = st.tflag;
  assign capture_flag_out = st.cflag;
  assign timer_irq_out = st.tflag & timer_irq_enable_in; // [R13]

  // ****************************************
  // assertions
  // ****************************************
  sequence at_match_s;
    tick && !period_capture_mode_select_in && st.count == st.cap[0];
  endsequence

  period_wrap_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    at_match_s |=> st.count == 16'h0000 && st.tflag) // [R11]
    else $error("no wrap at period match");
  stop_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !timer_run_in |=> st.count == $past(st.count)) // [R4]
    else $error("count moved while stopped");
  irq_gate_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    timer_irq_out == (st.tflag && timer_irq_enable_in)) // [R13]
    else $error("irq gating wrong");
  internal_rate_a: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    (timer_run_in && !clock_source_select_in)[*4] |->
      st.count != $past(st.count, 4)) // [R2]
    else $error("count did not advance in four cycles");
  cap_store_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    fire[1] |=> st.cap[1] == $past(st.count) && st.cflag[1]) // [R7] [R10]
    else $error("capture two not stored");
  ext_edge_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (timer_run_in && clock_source_select_in && fall[4] &&
      period_capture_mode_select_in) |=>
      st.count == 16'($past(st.count) + 16'h0001)) // [R3]
    else $error("external edge not counted");

  // a clear with no set event in the same cycle must take
  sequence flag_clear_s;
    timer_irq_flag_clear_in && !tick;
  endsequence

  flag_clear_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    flag_clear_s |=> !st.tflag) // [R14]
    else $error("timer flag not cleared");
  stop_flag_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !timer_run_in && !st.tflag |=> !st.tflag) // [R4]
    else $error("timer flag set while stopped");
  period_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !period_capture_mode_select_in && !period_write_in |=>
      $stable(st.cap[0])) // [R5] [R6]
    else $error("period register changed without a write");
  cap_one_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    fire[0] && period_capture_mode_select_in |=>
      st.cap[0] == $past(st.count) && st.cflag[0]) // [R7] [R10]
    else $error("capture one not stored");
endmodule // timer_with_four_capture

// File: verification/pin_source.sv
// behavioural source of the count pin and capture pin edges
`timescale 1ns/100ps
module pin_source
(
  input wire logic clk_in,
  output logic [4:0] pins_out
);
  initial pins_out = 5'h00;
  // n pulses on pin k; 4-cycle phases keep edges from merging
  task automatic pulse(input int k, input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk_in);
      pins_out[k] <= 1'b1;
      repeat (4) @(posedge clk_in);
      pins_out[k] <= 1'b0;
    end
  endtask
endmodule // pin_source

// File: verification/timer_with_four_capture_test.sv
// self-checking bench of the capture timer
`timescale 1ns/100ps
module timer_with_four_capture_test;
  logic clk = 1'b0, rst_n = 1'b0, src = 1'b0, run = 1'b0;
  logic mode = 1'b0, ien = 1'b0, fclr = 1'b0, pw = 1'b0;
  logic [15:0] pd = 16'h0007, c0;
  logic [7:0] em = 8'he4, ch, cl, ph, pl;
  logic [3:0] cclr = 4'h0, cf;
  logic [4:0] pins;
  logic [47:0] cap;
  logic tf, irq;
  int n_errors = 0, tests_run = 0, w;
  initial forever #25 clk = ~clk;
  pin_source pins_src (.clk_in(clk), .pins_out(pins));
  timer_with_four_capture DUT (.mclk_in(clk), .rst_n_in(rst_n),
    .clock_source_select_in(src), .timer_run_in(run),
    .period_capture_mode_select_in(mode), .timer_irq_enable_in(ien),
    .timer_irq_flag_clear_in(fclr), .period_write_in(pw),
    .period_data_in(pd), .edge_mode_in(em),
    .capture_flag_clear_in(cclr), .external_count_pin_in(pins[0]),
    .capture_pin_one_in(pins[1]), .capture_pin_two_in(pins[2]),
    .capture_pin_three_in(pins[3]), .capture_pin_four_in(pins[4]),
    .timer_count_high_out(ch), .timer_count_low_out(cl),
    .period_or_capture1_high_out(ph), .period_or_capture1_low_out(pl),
    .capture_234_out(cap), .timer_irq_flag_out(tf),
    .capture_flag_out(cf), .timer_irq_out(irq));
  // sample just after the edge so the design's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [47:0] g, e);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // period 7: wrap after 8 ticks of 4 cycles, then stop and clear
  task automatic t_period();
    @(posedge clk) pw <= 1'b1;
    @(posedge clk)
    begin
      pw <= 1'b0;
      run <= 1'b1;
    end
    for (w = 0; tf !== 1'b1 && w < 100; w++)
      tick(1);
    chk(w < 100, 1'b1);
    if (w == 100)
      give_verdict();
    chk(w >= 28 && w <= 36, 1'b1);
    chk({ch, cl, irq}, 17'h00000);
    @(posedge clk) ien <= 1'b1;
    tick(1);
    chk(irq, 1'b1);
    @(posedge clk) run <= 1'b0;
    @(posedge clk) fclr <= 1'b1;
    @(posedge clk) fclr <= 1'b0;
    tick(1);
    c0 = {ch, cl};
    tick(40);
    chk({ch, cl, tf, irq}, {c0, 2'b00});
    $display("period test done");
  endtask
  // one channel per edge code; the last qualifying edge sets the flag
  task automatic t_capture();
    int n;
    logic [15:0] v;
    @(posedge clk)
    begin
      mode <= 1'b1;
      run <= 1'b1;
    end
    for (int k = 0; k < 4; k++)
    begin
      n = (k < 2) ? 1 : (k == 2) ? 4 : 16;
      @(posedge clk) cclr <= 4'hf;
      @(posedge clk) cclr <= 4'h0;
      pins_src.pulse(k + 1, n - 1);
      tick(6);
      chk(cf, 4'h0);
      c0 = {ch, cl};
      pins_src.pulse(k + 1, 1);
      tick(6);
      chk(cf, 4'h1 << k);
      v = (k == 0) ? {ph, pl} : cap[16 * (k - 1) +: 16];
      chk(v >= c0 && v <= {ch, cl}, 1'b1);
    end
    $display("capture test done");
  endtask
  // five falling edges on the count pin advance the count by five
  task automatic t_extern();
    @(posedge clk) src <= 1'b1;
    tick(4);
    c0 = {ch, cl};
    pins_src.pulse(0, 5);
    tick(6);
    chk({ch, cl}, c0 + 16'h0005);
    $display("external count test done");
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    chk({ch, cl, ph, pl}, 32'h0000ffff);
    chk({tf, cf}, 5'h00);
    t_period();
    t_capture();
    t_extern();
    give_verdict();
  end
endmodule // timer_with_four_capture_test
